/* File: rtl/tssp_switch_map.vh */
/*
  Field layout and code constants of the tile static switch processor.
  Assumes it is included once by each design file that decodes switch words.
*/
`ifndef TSSP_SWITCH_MAP_VH
`define TSSP_SWITCH_MAP_VH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define TSSP_WORD_W 32
`define TSSP_INSTR_W 64
`define TSSP_PC_W 8
`define TSSP_IMEM_DEPTH 256
`define TSSP_REG_COUNT 4
`define TSSP_LINK_COUNT 5
`define TSSP_ROUTE_COUNT 6
`define TSSP_XOVER_SLOT 5
`define TSSP_BYTE_SHIFT 3

// ----------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------
`define TSSP_PR_BIT 63
`define TSSP_OP_HI 62
`define TSSP_OP_LO 59
`define TSSP_R_BIT 58
`define TSSP_IMM_HI 57
`define TSSP_IMM_LO 45
`define TSSP_EXT_HI 47
`define TSSP_EXT_LO 44
`define TSSP_OPER_HI 43
`define TSSP_OPER_LO 41
`define TSSP_RSRC_HI 40
`define TSSP_RSRC_LO 39
`define TSSP_RDST_HI 38
`define TSSP_RDST_LO 37
`define TSSP_SEC_HI 35
`define TSSP_SEC_LO 18
`define TSSP_PRI_HI 17
`define TSSP_PRI_LO 0

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define TSSP_OP_EXT 4'h0
`define TSSP_OP_LTZ 4'h1
`define TSSP_OP_NEZ 4'h2
`define TSSP_OP_GEZ 4'h3
`define TSSP_OP_JAL 4'h4
`define TSSP_OP_J 4'h5
`define TSSP_OP_GTZ 4'h6
`define TSSP_OP_EQZ 4'h7
`define TSSP_OP_LEZ 4'hC
`define TSSP_OP_NEZD 4'hD
`define TSSP_OP_EQZD 4'hE
`define TSSP_OP_DEBUG 4'hF
`define TSSP_EXT_NOP 4'h0
`define TSSP_EXT_MOVE 4'h1
`define TSSP_EXT_JR 4'h2
`define TSSP_EXT_JALR 4'h3

// ----------------------------------------------------------------
// Source port codes (per crossbar)
// ----------------------------------------------------------------
`define TSSP_SRC_NONE 3'h0
`define TSSP_SRC_PROC 3'h1
`define TSSP_SRC_WEST 3'h2
`define TSSP_SRC_SOUTH 3'h3
`define TSSP_SRC_EAST 3'h4
`define TSSP_SRC_NORTH 3'h5
`define TSSP_SRC_XOVER 3'h6
`define TSSP_SRC_REG 3'h7

// Link slot order inside the vector ports
`define TSSP_SLOT_NORTH 0
`define TSSP_SLOT_EAST 1
`define TSSP_SLOT_SOUTH 2
`define TSSP_SLOT_WEST 3
`define TSSP_SLOT_PROC 4

// ----------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------
`define TSSP_ST_IDLE 3'h1
`define TSSP_ST_LOAD 3'h2
`define TSSP_ST_RUN 3'h4

`endif

/* File: rtl/tssp_imem.v */
/*
  Switch instruction memory: one write port, one read port, registered read data.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tssp_switch_map.vh"

module tssp_imem (
  input wire core_clk,
  input wire rstn,
  input wire wrEn,
  input wire [`TSSP_PC_W-1:0] wrAddr,
  input wire [`TSSP_INSTR_W-1:0] wrData,
  input wire [`TSSP_PC_W-1:0] rdAddr,
  output reg [`TSSP_INSTR_W-1:0] rdData
);
  reg [`TSSP_INSTR_W-1:0] mem [0:`TSSP_IMEM_DEPTH-1];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= {`TSSP_INSTR_W{1'b0}};
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/tssp_switch.v */
/*
  Tile static switch processor: sequencer, 4-entry register file, primary and
  secondary crossbars with crossover slots.
  Assumes neighbours use valid/ready links and that the program obeys the
  legality limits on routes and register reads.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tssp_switch_map.vh"

module tssp_switch (
  input wire core_clk,
  input wire rstn,
  input wire runEn,
  input wire imemWrEn,
  input wire [`TSSP_PC_W-1:0] imemWrAddr,
  input wire [`TSSP_INSTR_W-1:0] imemWrData,
  input wire [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] priInData,
  input wire [`TSSP_LINK_COUNT-1:0] priInValid,
  output wire [`TSSP_LINK_COUNT-1:0] priInReady,
  output reg [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] priOutData,
  output reg [`TSSP_LINK_COUNT-1:0] priOutValid,
  input wire [`TSSP_LINK_COUNT-1:0] priOutReady,
  input wire [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] secInData,
  input wire [`TSSP_LINK_COUNT-1:0] secInValid,
  output wire [`TSSP_LINK_COUNT-1:0] secInReady,
  output reg [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] secOutData,
  output reg [`TSSP_LINK_COUNT-1:0] secOutValid,
  input wire [`TSSP_LINK_COUNT-1:0] secOutReady,
  output reg [`TSSP_PC_W-1:0] curPc,
  output wire instrFire
);
  // ----------------------------------------------------------------
  // Source decode helpers
  // ----------------------------------------------------------------
  function [`TSSP_LINK_COUNT-1:0] srcMask;
    input [2:0] code;
    begin
      srcMask = {`TSSP_LINK_COUNT{1'b0}};
      case (code)
        `TSSP_SRC_NORTH: srcMask[`TSSP_SLOT_NORTH] = 1'b1;
        `TSSP_SRC_EAST: srcMask[`TSSP_SLOT_EAST] = 1'b1;
        `TSSP_SRC_SOUTH: srcMask[`TSSP_SLOT_SOUTH] = 1'b1;
        `TSSP_SRC_WEST: srcMask[`TSSP_SLOT_WEST] = 1'b1;
        `TSSP_SRC_PROC: srcMask[`TSSP_SLOT_PROC] = 1'b1;
        default: srcMask = {`TSSP_LINK_COUNT{1'b0}};
      endcase
    end
  endfunction

  function [`TSSP_WORD_W-1:0] pick;
    input [2:0] code;
    input [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] din;
    input [`TSSP_WORD_W-1:0] xin;
    input [`TSSP_WORD_W-1:0] rr;
    begin
      case (code)
        `TSSP_SRC_NORTH: pick = din[`TSSP_SLOT_NORTH*`TSSP_WORD_W +: `TSSP_WORD_W];
        `TSSP_SRC_EAST: pick = din[`TSSP_SLOT_EAST*`TSSP_WORD_W +: `TSSP_WORD_W];
        `TSSP_SRC_SOUTH: pick = din[`TSSP_SLOT_SOUTH*`TSSP_WORD_W +: `TSSP_WORD_W];
        `TSSP_SRC_WEST: pick = din[`TSSP_SLOT_WEST*`TSSP_WORD_W +: `TSSP_WORD_W];
        `TSSP_SRC_PROC: pick = din[`TSSP_SLOT_PROC*`TSSP_WORD_W +: `TSSP_WORD_W];
        `TSSP_SRC_XOVER: pick = xin;
        `TSSP_SRC_REG: pick = rr;
        default: pick = {`TSSP_WORD_W{1'b0}};
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Fetch and field decode
  // ----------------------------------------------------------------
  reg [2:0] state;
  reg [`TSSP_PC_W-1:0] fetchAddr;
  wire [`TSSP_INSTR_W-1:0] instr;
  reg [`TSSP_WORD_W-1:0] regs [0:`TSSP_REG_COUNT-1];
  reg [`TSSP_WORD_W-1:0] xToSec;
  reg xToSecValid;
  reg [`TSSP_WORD_W-1:0] xToPri;
  reg xToPriValid;

  tssp_imem imem (
    .core_clk(core_clk),
    .rstn(rstn),
    .wrEn(imemWrEn),
    .wrAddr(imemWrAddr),
    .wrData(imemWrData),
    .rdAddr(fetchAddr),
    .rdData(instr)
  );

  wire [3:0] opc = instr[`TSSP_OP_HI:`TSSP_OP_LO];
  wire relBit = instr[`TSSP_R_BIT];
  wire [`TSSP_PC_W-1:0] imm = instr[`TSSP_IMM_LO +: `TSSP_PC_W];
  wire [3:0] extOp = instr[`TSSP_EXT_HI:`TSSP_EXT_LO];
  wire [2:0] operSel = instr[`TSSP_OPER_HI:`TSSP_OPER_LO];
  wire [1:0] rsrc = instr[`TSSP_RSRC_HI:`TSSP_RSRC_LO];
  wire [1:0] rdst = instr[`TSSP_RDST_HI:`TSSP_RDST_LO];
  wire [`TSSP_ROUTE_COUNT*3-1:0] priRoute = instr[`TSSP_PRI_HI:`TSSP_PRI_LO];
  wire [`TSSP_ROUTE_COUNT*3-1:0] secRoute = instr[`TSSP_SEC_HI:`TSSP_SEC_LO];
  wire isExt = (opc == `TSSP_OP_EXT);
  wire usesOper = !(opc == `TSSP_OP_JAL || opc == `TSSP_OP_J || opc == `TSSP_OP_DEBUG ||
    (isExt && extOp == `TSSP_EXT_NOP));
  wire running = (state == `TSSP_ST_RUN);

  // Single read port: every register read uses the rsrc index
  wire [`TSSP_WORD_W-1:0] regRd = regs[rsrc];
  // Operand comes from the primary port map or the register, never written back to a port
  wire [`TSSP_WORD_W-1:0] operand = pick(operSel, priInData, xToPri, regRd);

  // ----------------------------------------------------------------
  // Crossbars and stall logic
  // ----------------------------------------------------------------
  reg [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] priVal;
  reg [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] secVal;
  reg [`TSSP_WORD_W-1:0] priXVal;
  reg [`TSSP_WORD_W-1:0] secXVal;
  reg [`TSSP_ROUTE_COUNT-1:0] priDest;
  reg [`TSSP_ROUTE_COUNT-1:0] secDest;
  reg [`TSSP_LINK_COUNT-1:0] priNeed;
  reg [`TSSP_LINK_COUNT-1:0] secNeed;
  reg priReadsX;
  reg secReadsX;
  reg destOk;
  integer k;
  integer m;

  always @* begin
    priNeed = usesOper ? srcMask(operSel) : {`TSSP_LINK_COUNT{1'b0}};
    secNeed = {`TSSP_LINK_COUNT{1'b0}};
    priReadsX = usesOper && (operSel == `TSSP_SRC_XOVER);
    secReadsX = 1'b0;
    priVal = {`TSSP_LINK_COUNT*`TSSP_WORD_W{1'b0}};
    secVal = {`TSSP_LINK_COUNT*`TSSP_WORD_W{1'b0}};
    priXVal = {`TSSP_WORD_W{1'b0}};
    secXVal = {`TSSP_WORD_W{1'b0}};
    for (k = 0; k < `TSSP_ROUTE_COUNT; k = k + 1) begin
      // Each crossbar sees only its own ports, so no direct cross-network route exists
      priDest[k] = (priRoute[3*k +: 3] != `TSSP_SRC_NONE);
      secDest[k] = (secRoute[3*k +: 3] != `TSSP_SRC_NONE);
      priNeed = priNeed | srcMask(priRoute[3*k +: 3]);
      secNeed = secNeed | srcMask(secRoute[3*k +: 3]);
      priReadsX = priReadsX | (priRoute[3*k +: 3] == `TSSP_SRC_XOVER);
      secReadsX = secReadsX | (secRoute[3*k +: 3] == `TSSP_SRC_XOVER);
      if (k == `TSSP_XOVER_SLOT) begin
        priXVal = pick(priRoute[3*k +: 3], priInData, xToPri, regRd);
        secXVal = pick(secRoute[3*k +: 3], secInData, xToSec, regRd);
      end else begin
        priVal[k*`TSSP_WORD_W +: `TSSP_WORD_W] = pick(priRoute[3*k +: 3], priInData, xToPri, regRd);
        secVal[k*`TSSP_WORD_W +: `TSSP_WORD_W] = pick(secRoute[3*k +: 3], secInData, xToSec, regRd);
      end
    end
    destOk = 1'b1;
    for (k = 0; k < `TSSP_LINK_COUNT; k = k + 1) begin
      if (priDest[k] && priOutValid[k] && !priOutReady[k]) begin
        destOk = 1'b0;
      end
      if (secDest[k] && secOutValid[k] && !secOutReady[k]) begin
        destOk = 1'b0;
      end
    end
    if (priDest[`TSSP_XOVER_SLOT] && xToSecValid && !secReadsX) begin
      destOk = 1'b0;
    end
    if (secDest[`TSSP_XOVER_SLOT] && xToPriValid && !priReadsX) begin
      destOk = 1'b0;
    end
  end

  wire srcOk = (&(~priNeed | priInValid)) && (&(~secNeed | secInValid)) &&
    (!priReadsX || xToPriValid) && (!secReadsX || xToSecValid);
  assign instrFire = running && srcOk && destOk;
  assign priInReady = instrFire ? priNeed : {`TSSP_LINK_COUNT{1'b0}};
  assign secInReady = instrFire ? secNeed : {`TSSP_LINK_COUNT{1'b0}};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  reg taken;
  reg [`TSSP_PC_W-1:0] target;
  reg regWr;
  reg [`TSSP_WORD_W-1:0] regWrData;
  wire [`TSSP_PC_W-1:0] pcPlus = curPc + 1'b1;
  wire [`TSSP_WORD_W-1:0] linkVal = {{(`TSSP_WORD_W-`TSSP_PC_W-`TSSP_BYTE_SHIFT){1'b0}}, pcPlus,
    {`TSSP_BYTE_SHIFT{1'b0}}};
  wire [`TSSP_PC_W-1:0] immTarget = relBit ? curPc + imm : imm;
  wire [`TSSP_PC_W-1:0] indTarget = operand[`TSSP_BYTE_SHIFT +: `TSSP_PC_W];
  wire operZero = (operand == {`TSSP_WORD_W{1'b0}});
  wire operNeg = operand[`TSSP_WORD_W-1];

  always @* begin
    taken = 1'b0;
    target = immTarget;
    regWr = 1'b0;
    regWrData = linkVal;
    case (opc)
      `TSSP_OP_LTZ: taken = operNeg;
      `TSSP_OP_NEZ: taken = !operZero;
      `TSSP_OP_GEZ: taken = !operNeg;
      `TSSP_OP_GTZ: taken = !operNeg && !operZero;
      `TSSP_OP_EQZ: taken = operZero;
      `TSSP_OP_LEZ: taken = operNeg || operZero;
      `TSSP_OP_J: taken = 1'b1;
      `TSSP_OP_JAL: begin
        taken = 1'b1;
        regWr = 1'b1;
      end
      `TSSP_OP_NEZD, `TSSP_OP_EQZD: begin
        taken = (opc == `TSSP_OP_EQZD) ? operZero : !operZero;
        regWr = 1'b1;
        regWrData = operand - 1'b1;
      end
      `TSSP_OP_EXT: begin
        target = indTarget;
        case (extOp)
          `TSSP_EXT_MOVE: begin
            regWr = 1'b1;
            regWrData = operand;
          end
          `TSSP_EXT_JR: taken = 1'b1;
          `TSSP_EXT_JALR: begin
            taken = 1'b1;
            regWr = 1'b1;
          end
          default: taken = 1'b0;
        endcase
      end
      default: taken = 1'b0;
    endcase
  end

  wire [`TSSP_PC_W-1:0] nextPc = taken ? target : pcPlus;
  reg [2:0] next_state;

  always @* begin
    next_state = state;
    fetchAddr = curPc;
    case (state)
      `TSSP_ST_IDLE: begin
        fetchAddr = {`TSSP_PC_W{1'b0}};
        if (runEn) begin
          next_state = `TSSP_ST_LOAD;
        end
      end
      `TSSP_ST_LOAD: next_state = runEn ? `TSSP_ST_RUN : `TSSP_ST_IDLE;
      `TSSP_ST_RUN: begin
        if (!runEn) begin
          next_state = `TSSP_ST_IDLE;
        end else if (instrFire) begin
          fetchAddr = nextPc;
        end
      end
      default: next_state = `TSSP_ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // State, register file, outputs and crossover slots
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= `TSSP_ST_IDLE;
      curPc <= {`TSSP_PC_W{1'b0}};
      for (m = 0; m < `TSSP_REG_COUNT; m = m + 1) begin
        regs[m] <= {`TSSP_WORD_W{1'b0}};
      end
      priOutData <= {`TSSP_LINK_COUNT*`TSSP_WORD_W{1'b0}};
      secOutData <= {`TSSP_LINK_COUNT*`TSSP_WORD_W{1'b0}};
      priOutValid <= {`TSSP_LINK_COUNT{1'b0}};
      secOutValid <= {`TSSP_LINK_COUNT{1'b0}};
      xToSec <= {`TSSP_WORD_W{1'b0}};
      xToPri <= {`TSSP_WORD_W{1'b0}};
      xToSecValid <= 1'b0;
      xToPriValid <= 1'b0;
    end else begin
      state <= next_state;
      curPc <= (next_state == `TSSP_ST_IDLE) ? {`TSSP_PC_W{1'b0}} : fetchAddr;
      if (instrFire && regWr) begin
        regs[rdst] <= regWrData;
      end
      for (m = 0; m < `TSSP_LINK_COUNT; m = m + 1) begin
        if (instrFire && priDest[m]) begin
          priOutData[m*`TSSP_WORD_W +: `TSSP_WORD_W] <= priVal[m*`TSSP_WORD_W +: `TSSP_WORD_W];
          priOutValid[m] <= 1'b1;
        end else if (priOutReady[m]) begin
          priOutValid[m] <= 1'b0;
        end
        if (instrFire && secDest[m]) begin
          secOutData[m*`TSSP_WORD_W +: `TSSP_WORD_W] <= secVal[m*`TSSP_WORD_W +: `TSSP_WORD_W];
          secOutValid[m] <= 1'b1;
        end else if (secOutReady[m]) begin
          secOutValid[m] <= 1'b0;
        end
      end
      // Crossover words become readable by the other crossbar on the next cycle
      if (instrFire && priDest[`TSSP_XOVER_SLOT]) begin
        xToSec <= priXVal;
        xToSecValid <= 1'b1;
      end else if (instrFire && secReadsX) begin
        xToSecValid <= 1'b0;
      end
      if (instrFire && secDest[`TSSP_XOVER_SLOT]) begin
        xToPri <= secXVal;
        xToPriValid <= 1'b1;
      end else if (instrFire && priReadsX) begin
        xToPriValid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dv/tssp_switch_sva.sv */
/*
  Port checker for tssp_switch: link handshakes and sequencer stalls.
  Assumes it is bound to the switch top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tssp_switch_map.vh"
module tssp_switch_sva (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic runEn,
  input wire logic [`TSSP_LINK_COUNT-1:0] priInValid,
  input wire logic [`TSSP_LINK_COUNT-1:0] priInReady,
  input wire logic [`TSSP_LINK_COUNT-1:0] priOutValid,
  input wire logic [`TSSP_LINK_COUNT-1:0] priOutReady,
  input wire logic [`TSSP_LINK_COUNT-1:0] secInValid,
  input wire logic [`TSSP_LINK_COUNT-1:0] secInReady,
  input wire logic [`TSSP_LINK_COUNT-1:0] secOutValid,
  input wire logic [`TSSP_LINK_COUNT-1:0] secOutReady,
  input wire logic [`TSSP_PC_W-1:0] curPc,
  input wire logic instrFire
);
  // ------------------------------
  // Handshake and sequencer checks
  // ------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  chk_pri_take_valid: assert property ((priInReady & ~priInValid) == 5'h00)
    else $error("primary word taken while absent");
  chk_sec_take_valid: assert property ((secInReady & ~secInValid) == 5'h00)
    else $error("secondary word taken while absent");
  chk_take_needs_fire: assert property (|{priInReady, secInReady} |-> instrFire)
    else $error("input taken without instruction");
  chk_pri_out_hold: assert property (|(priOutValid & ~priOutReady) |=>
    (priOutValid & $past(priOutValid & ~priOutReady)) == $past(priOutValid & ~priOutReady))
    else $error("primary output dropped before taken");
  chk_sec_out_hold: assert property (|(secOutValid & ~secOutReady) |=>
    (secOutValid & $past(secOutValid & ~secOutReady)) == $past(secOutValid & ~secOutReady))
    else $error("secondary output dropped before taken");
  chk_pri_out_drop: assert property ((!instrFire && |(priOutValid & priOutReady)) |=>
    (priOutValid & $past(priOutValid & priOutReady)) == 5'h00)
    else $error("primary output kept after take");
  chk_valid_cause: assert property (!instrFire |=>
    ((priOutValid & ~$past(priOutValid)) | (secOutValid & ~$past(secOutValid))) == 5'h00)
    else $error("output loaded without instruction");
  chk_pc_hold: assert property ((!instrFire && runEn) ##1 runEn |-> $stable(curPc))
    else $error("pc moved without instruction");
  chk_pc_idle: assert property (!runEn |=> (curPc == 8'h00) && !instrFire)
    else $error("sequencer active while disabled");
endmodule
`default_nettype wire

/* File: dv/tssp_link_partner.sv */
/*
  Neighbour model for one network of the switch: word sources and word sinks.
  Assumes one instance per crossbar; the bench queues words with send.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tssp_switch_map.vh"
module tssp_link_partner (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] mode,
  input wire logic [`TSSP_LINK_COUNT-1:0] inReady,
  output logic [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] inData,
  output logic [`TSSP_LINK_COUNT-1:0] inValid,
  output logic [`TSSP_LINK_COUNT-1:0] outReady
);
  logic [31:0] pend [`TSSP_LINK_COUNT][$];
  task automatic send(input int slot, input logic [31:0] w);
    pend[slot].push_back(w);
  endtask
  // ------------------------------
  // Sources hold until taken, idle lines toggle; sinks ready by mode
  // ------------------------------
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      inValid <= '0;
      inData <= '0;
      outReady <= '0;
    end else begin
      for (int i = 0; i < `TSSP_LINK_COUNT; i++) begin
        if (inValid[i] && inReady[i]) begin
          void'(pend[i].pop_front());
        end
        if (pend[i].size() > 0) begin
          inValid[i] <= 1'b1;
          inData[32*i +: 32] <= pend[i][0];
        end else begin
          inValid[i] <= 1'b0;
          inData[32*i +: 32] <= ~inData[32*i +: 32];
        end
      end
      outReady <= mode == 2'h0 ? 5'h1F : mode == 2'h1 ? 5'($urandom) : 5'h00;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
/*
  Self-checking bench for tssp_switch: loads programs, feeds both networks, scores outputs.
  Assumes the link partner model and the port checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tssp_switch_map.vh"
bind tssp_switch tssp_switch_sva u_sva (.core_clk(core_clk), .rstn(rstn), .runEn(runEn),
  .priInValid(priInValid), .priInReady(priInReady), .priOutValid(priOutValid), .priOutReady(priOutReady),
  .secInValid(secInValid), .secInReady(secInReady), .secOutValid(secOutValid), .secOutReady(secOutReady),
  .curPc(curPc), .instrFire(instrFire));
module tb;
  localparam logic [2:0] SN = `TSSP_SRC_NORTH;
  localparam logic [2:0] SR = `TSSP_SRC_REG;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic runEn = 1'b0;
  logic imemWrEn = 1'b0;
  logic [`TSSP_PC_W-1:0] imemWrAddr = '0;
  logic [`TSSP_INSTR_W-1:0] imemWrData = '0;
  logic [1:0] priMode = 2'h1;
  logic [1:0] secMode = 2'h1;
  logic [`TSSP_LINK_COUNT*`TSSP_WORD_W-1:0] priInData, priOutData, secInData, secOutData;
  logic [`TSSP_LINK_COUNT-1:0] priInValid, priInReady, priOutValid, priOutReady;
  logic [`TSSP_LINK_COUNT-1:0] secInValid, secInReady, secOutValid, secOutReady;
  logic [`TSSP_PC_W-1:0] curPc;
  logic instrFire;
  logic [63:0] prog [8];
  logic [35:0] expq [$];
  int errorCnt = 0;
  int nCompared = 0;
  int cyc = 0;
  always #5 core_clk = ~core_clk;
  tssp_switch i_dut (.core_clk(core_clk), .rstn(rstn), .runEn(runEn), .imemWrEn(imemWrEn),
    .imemWrAddr(imemWrAddr), .imemWrData(imemWrData), .priInData(priInData), .priInValid(priInValid),
    .priInReady(priInReady), .priOutData(priOutData), .priOutValid(priOutValid), .priOutReady(priOutReady),
    .secInData(secInData), .secInValid(secInValid), .secInReady(secInReady), .secOutData(secOutData),
    .secOutValid(secOutValid), .secOutReady(secOutReady), .curPc(curPc), .instrFire(instrFire));
  tssp_link_partner u_pri (.core_clk(core_clk), .rstn(rstn), .mode(priMode), .inReady(priInReady),
    .inData(priInData), .inValid(priInValid), .outReady(priOutReady));
  tssp_link_partner u_sec (.core_clk(core_clk), .rstn(rstn), .mode(secMode), .inReady(secInReady),
    .inData(secInData), .inValid(secInValid), .outReady(secOutReady));
  // ------------------------------
  // Program builders and bench tasks
  // ------------------------------
  function automatic logic [17:0] rt(input int k, input logic [2:0] s);
    return 18'(s) << (3 * k);
  endfunction
  function automatic logic [63:0] ins(input logic [3:0] op, input logic [7:0] imm, input logic [17:0] pr,
      input logic [17:0] sc);
    logic [63:0] w;
    w = 64'h0;
    w[`TSSP_OP_HI:`TSSP_OP_LO] = op;
    w[`TSSP_IMM_LO+7:`TSSP_IMM_LO] = imm;
    w[`TSSP_SEC_HI:`TSSP_SEC_LO] = sc;
    w[`TSSP_PRI_HI:`TSSP_PRI_LO] = pr;
    return w;
  endfunction
  function automatic logic [63:0] xop(input logic [3:0] ext, input logic [2:0] src, input logic [1:0] rs,
      input logic [1:0] rd, input logic [17:0] pr, input logic [17:0] sc);
    logic [63:0] w;
    w = ins(`TSSP_OP_EXT, 8'h00, pr, sc);
    w[`TSSP_EXT_HI:`TSSP_EXT_LO] = ext;
    w[`TSSP_OPER_HI:`TSSP_OPER_LO] = src;
    w[`TSSP_RSRC_HI:`TSSP_RSRC_LO] = rs;
    w[`TSSP_RDST_HI:`TSSP_RDST_LO] = rd;
    return w;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic note(input int key, input logic [31:0] w);
    expq.push_back({4'(key), w});
  endtask
  task automatic put(input logic sec, input int slot, input logic [31:0] w);
    @(negedge core_clk);
    if (sec) u_sec.send(slot, w);
    else u_pri.send(slot, w);
  endtask
  task automatic load(input int n);
    @(posedge core_clk);
    runEn <= 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      imemWrEn <= 1'b1;
      imemWrAddr <= 8'(i);
      imemWrData <= prog[i];
    end
    @(posedge core_clk);
    imemWrEn <= 1'b0;
    runEn <= 1'b1;
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (expq.size() > 0 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    repeat (4) @(posedge core_clk);
    chk(32'(expq.size()), 32'h0);
  endtask
  task automatic tallyAndFinish();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ------------------------------
  // Output monitor and watchdog
  // ------------------------------
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      tallyAndFinish();
    end
  end
  always @(posedge core_clk) begin
    logic [31:0] got;
    int hit;
    for (int i = 0; i < 10; i++) begin
      if (rstn && (i < 5 ? priOutValid[i] && priOutReady[i] : secOutValid[i-5] && secOutReady[i-5])) begin
        got = i < 5 ? priOutData[32*i +: 32] : secOutData[32*(i-5) +: 32];
        hit = -1;
        for (int j = expq.size() - 1; j >= 0; j--) begin
          if (expq[j][35:32] == 4'(i)) hit = j;
        end
        if (hit < 0) chk(got, ~got);
        else chk(got, expq[hit][31:0]);
        if (hit >= 0) expq.delete(hit);
      end
    end
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] vals [4];
    logic tk;
    logic [3:0] ops [8];
    void'($urandom(40));
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    prog[0] = ins(`TSSP_OP_J, 8'h00, rt(1, SN) | rt(4, `TSSP_SRC_WEST), rt(3, `TSSP_SRC_SOUTH));
    load(1);
    for (int i = 0; i < 8; i++) begin
      a = $urandom;
      b = $urandom;
      note(1, a);
      note(4, ~a);
      note(8, b);
      put(0, 0, a);
      put(0, 3, ~a);
      put(1, 2, b);
    end
    drain();
    $display("test stream done");
    prog[0] = xop(`TSSP_EXT_MOVE, SN, 2'h0, 2'h2, 0, 0);
    prog[1] = xop(`TSSP_EXT_NOP, 3'h0, 2'h2, 2'h0, rt(1, SR) | rt(2, SR), rt(0, SR));
    prog[2] = xop(`TSSP_EXT_JALR, SN, 2'h0, 2'h3, 0, 0);
    prog[3] = xop(`TSSP_EXT_NOP, 3'h0, 2'h3, 2'h0, rt(2, SR), 0);
    prog[4] = xop(`TSSP_EXT_NOP, 3'h0, 2'h3, 2'h0, rt(1, SR), 0);
    prog[5] = xop(`TSSP_EXT_JR, SN, 2'h0, 2'h0, 0, 0);
    prog[6] = prog[3];
    prog[7] = ins(`TSSP_OP_J, 8'h07, 0, 0);
    a = $urandom;
    note(1, a);
    note(2, a);
    note(5, a);
    note(1, 32'h18);
    load(8);
    put(0, 0, a);
    put(0, 0, 32'h20);
    put(0, 0, 32'h38);
    drain();
    chk(32'(curPc), 32'h7);
    $display("test register done");
    prog[0] = ins(`TSSP_OP_EXT, 8'h00, rt(`TSSP_XOVER_SLOT, SN), rt(`TSSP_XOVER_SLOT, `TSSP_SRC_WEST));
    prog[1] = ins(`TSSP_OP_EXT, 8'h00, rt(3, `TSSP_SRC_XOVER), rt(1, `TSSP_SRC_XOVER));
    prog[2] = ins(`TSSP_OP_J, 8'h02, 0, 0);
    a = $urandom;
    b = $urandom;
    note(6, a);
    note(3, b);
    load(3);
    put(0, 0, a);
    put(1, 3, b);
    drain();
    $display("test crossover done");
    vals = '{32'h0, 32'h1, 32'hFFFFFFFF, $urandom};
    ops = '{`TSSP_OP_GEZ, `TSSP_OP_GTZ, `TSSP_OP_LTZ, `TSSP_OP_NEZ, `TSSP_OP_EQZ, `TSSP_OP_LEZ, `TSSP_OP_NEZD,
      `TSSP_OP_EQZD};
    for (int n = 0; n < 64; n++) begin
      a = vals[n % 4];
      prog[0] = xop(`TSSP_EXT_MOVE, SN, 2'h0, 2'h1, 0, 0);
      prog[1] = xop(`TSSP_EXT_NOP, SR, 2'h1, 2'h0, 0, 0);
      prog[1][`TSSP_OP_HI:`TSSP_OP_LO] = ops[n[4:2]];
      prog[1][`TSSP_R_BIT] = n[5];
      prog[1][`TSSP_IMM_LO+7:`TSSP_IMM_LO] = n[5] ? 8'h04 : 8'h05;
      prog[2] = xop(`TSSP_EXT_NOP, 3'h0, 2'h1, 2'h0, rt(2, SR), 0);
      prog[3] = ins(`TSSP_OP_J, 8'h03, 0, 0);
      prog[4] = prog[3];
      prog[5] = xop(`TSSP_EXT_NOP, 3'h0, 2'h1, 2'h0, rt(1, SR), 0);
      prog[6] = ins(`TSSP_OP_J, 8'h06, 0, 0);
      case (n[4:2])
        3'h0: tk = !a[31];
        3'h1: tk = !a[31] && a != 32'h0;
        3'h2: tk = a[31];
        3'h3, 3'h6: tk = a != 32'h0;
        3'h5: tk = a[31] || a == 32'h0;
        default: tk = a == 32'h0;
      endcase
      note(tk ? 1 : 2, a);
      load(7);
      put(0, 0, a);
      drain();
      chk(32'(curPc), tk ? 32'h6 : 32'h3);
    end
    $display("test branch done");
    priMode <= 2'h2;
    prog[0] = ins(`TSSP_OP_EXT, 8'h00, rt(1, SN), 0);
    prog[1] = ins(`TSSP_OP_EXT, 8'h00, rt(1, `TSSP_SRC_WEST), 0);
    prog[2] = ins(`TSSP_OP_J, 8'h02, 0, 0);
    load(3);
    repeat (10) @(posedge core_clk);
    chk(32'(curPc), 32'h0);
    a = $urandom;
    b = $urandom;
    note(1, a);
    note(1, b);
    put(0, 0, a);
    put(0, 3, b);
    repeat (10) @(posedge core_clk);
    chk(32'(curPc), 32'h1);
    chk(32'(priInValid), 32'h8);
    priMode <= 2'h0;
    drain();
    chk(32'(curPc), 32'h2);
    $display("test stall done");
    tallyAndFinish();
  end
endmodule
`default_nettype wire
